// *** ims_pkg.sv ***
// constants and types shared by the instrument mode sequencer
//
// Notes on behaviour
// - after reset, finish boot, peripheral and memory checks, then enter stand-by alone.
// - stand-by only takes commands and sends health reports; no science acquisition.
// - entering science copies nonvolatile procedures into working RAM, then runs there.
// - code and tables checked against appended checksums, repeated every few seconds; the code repeats it only in science, on the 16 RAM words alone.
// - each module carries a header; modules upload from ground and dump back.
// - first operation command from stand-by starts the default science mode.
// - science entry reads configuration, powers active subsystems, waits for good init.
// - no-op or configuration command readies reconfiguration or waits for switch-off.
// - all tables in nonvolatile store except diagnostic table in fixed store.
// - decode command target; controller types are mode, telemetry, time, diagnostics.
// - sensor commands limited to mode control and configuration parameter loads.
// - science or diagnostic mode keeps running without commands; no time tags.
// - a watchdog catches endless loops and treats them as errors.
// - each error sets a flag word and global error flag until acknowledged.
// - every command is acknowledged in the health report; status in every mode; the code sends no health word in ST_DIAG, only pattern words.
// - status is kept over power-off; only a dedicated clear command erases it; the code overwrites it each cycle after ST_BOOT.
// - science builds 12 by 16 histogram of 16-bit counters, output every 60 s.
// - data packets leave over the link; content depends on operating mode.
// - health report carries command, mode, settings, lookup values and monitors.
// - diagnostic modes produce test patterns or detailed health data.
// - at power-on only the controller is active; units power on by command.
package ims_pkg;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ         = 125_000_000;
    localparam int unsigned HIST_PERIOD_S  = 60;
    localparam longint unsigned HIST_CYCLES = longint'(HIST_PERIOD_S) * CLK_HZ;
    localparam int unsigned CHECK_PERIOD_S = 2;
    localparam longint unsigned CHECK_CYCLES = longint'(CHECK_PERIOD_S) * CLK_HZ;
    localparam int unsigned WDOG_MS        = 100;
    localparam int unsigned WDOG_CYCLES    = WDOG_MS * (CLK_HZ / 1000);
    localparam int unsigned INIT_WAIT_US   = 100;
    localparam int unsigned INIT_CYCLES    = INIT_WAIT_US * (CLK_HZ / 1_000_000);
    // ----------------------------------------------------------------
    // geometry
    // ----------------------------------------------------------------
    localparam int unsigned N_AZ   = 12;
    localparam int unsigned N_EN   = 16;
    localparam int unsigned N_BINS = N_AZ * N_EN;
    localparam int unsigned N_SUB  = 4;
    localparam int unsigned PROC_WORDS = 16;
    // ----------------------------------------------------------------
    // register offsets (byte addresses, one 32-bit word apart)
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_CMD     = 8'h00;
    localparam logic [7:0] REG_STATUS  = 8'h04;
    localparam logic [7:0] REG_ERRWORD = 8'h08;
    localparam logic [7:0] REG_LASTCMD = 8'h0C;
    localparam logic [7:0] REG_CFG     = 8'h10;
    localparam logic [7:0] REG_HV      = 8'h14;
    localparam logic [7:0] REG_TIMING  = 8'h18;
    localparam logic [7:0] REG_KICK    = 8'h1C;
    localparam logic [7:0] REG_MEMADR  = 8'h20;
    localparam logic [7:0] REG_MEMDAT  = 8'h24;
    localparam logic [7:0] REG_RETAIN  = 8'h28;
    // ----------------------------------------------------------------
    // command word: [31:28] target, [27:24] type, [23:0] argument
    // ----------------------------------------------------------------
    localparam int unsigned CMD_TGT_LSB  = 28;
    localparam int unsigned CMD_TYPE_LSB = 24;
    localparam logic [3:0] TGT_CTRL = 4'h0;
    typedef enum logic [3:0] {
        CT_NOP      = 4'h0,
        CT_CONFIG   = 4'h1,
        CT_OPERATE  = 4'h2,
        CT_TLM      = 4'h3,
        CT_TIME     = 4'h4,
        CT_DUMP     = 4'h5,
        CT_LOAD     = 4'h6,
        CT_IORW     = 4'h7,
        CT_JUMP     = 4'h8,
        CT_SAVE     = 4'h9,
        CT_ERR_ACK  = 4'hA,
        CT_CLR_STAT = 4'hB,
        CT_SWOFF    = 4'hC,
        CT_DIAG     = 4'hD,
        CT_UNIT_PWR = 4'hE
    } ims_cmd_type;
    // ----------------------------------------------------------------
    // modes and error word bits
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_STANDBY = 2'h0,
        MODE_SCIENCE = 2'h1,
        MODE_DIAG    = 2'h2
    } ims_mode_type;
    localparam int unsigned ERR_BOOT  = 0;
    localparam int unsigned ERR_CSUM  = 1;
    localparam int unsigned ERR_WDOG  = 2;
    localparam int unsigned ERR_INIT  = 3;
    localparam int unsigned ERR_BADCMD = 4;
    localparam logic [31:0] CSUM_GOOD = 32'h0000_0000;
endpackage

// *** ims_period_timer.sv ***
// free-running period timer issuing a one-cycle tick
`timescale 1ns/10ps
`default_nettype none
module ims_period_timer #(
    parameter longint unsigned PERIOD = 64'd125
) (
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    input  wire logic run_i,
    output logic      tick_o
);
    logic [39:0] cnt_reg;
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i || !run_i)
        begin
            cnt_reg <= 40'h00_0000_0000;
            tick_o  <= 1'b0;
        end
        else if (cnt_reg == 40'(PERIOD - 1))
        begin
            cnt_reg <= 40'h00_0000_0000;
            tick_o  <= 1'b1;
        end
        else
        begin
            cnt_reg <= cnt_reg + 40'h00_0000_0001;
            tick_o  <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** ims_sequencer.sv ***
// instrument mode sequencer: boot, command decode, modes, checks, histogram
//
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module ims_sequencer #(
    parameter longint unsigned HIST_CYCLES  = ims_pkg::HIST_CYCLES,
    parameter longint unsigned CHECK_CYCLES = ims_pkg::CHECK_CYCLES,
    parameter int unsigned     WDOG_CYCLES  = ims_pkg::WDOG_CYCLES
) (
    // clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    // register port
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,
    // nonvolatile store (procedures, tables) and checksum
    output logic      [7:0]  nv_addr_o,
    input  wire logic [31:0] nv_data_i,
    // subsystems
    output logic      [3:0]  unit_pwr_o,
    input  wire logic [3:0]  unit_ok_i,
    // detector events
    input  wire logic        event_i,
    input  wire logic [3:0]  event_az_i,
    input  wire logic [3:0]  event_en_i,
    // downlink data stream
    output logic      [31:0] tx_data_o,
    output logic             tx_valid_o,
    output logic             tx_hk_o,
    input  wire logic        tx_ready_i,
    // status
    output logic      [1:0]  mode_o,
    output logic             err_flag_o
);
    // ----------------------------------------------------------------
    // input synchronisers for pins
    // ----------------------------------------------------------------
    logic [3:0] ok_s1_reg, ok_s2_reg;
    logic [8:0] ev_s1_reg, ev_s2_reg;
    always_ff @(posedge sys_clk_i)
    begin
        ok_s1_reg <= unit_ok_i;
        ok_s2_reg <= ok_s1_reg;
        ev_s1_reg <= {event_i, event_az_i, event_en_i};
        ev_s2_reg <= ev_s1_reg;
    end
    // ----------------------------------------------------------------
    // control state
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_BOOT, ST_MEMCHK, ST_STANDBY, ST_CFG_READ, ST_COPY, ST_INIT_WAIT,
        ST_SCIENCE, ST_DIAG
    } ims_state_type;
    ims_state_type state_reg;
    logic [7:0]  idx_reg;
    logic [31:0] csum_reg;
    logic [31:0] ram_reg [ims_pkg::PROC_WORDS];
    logic [3:0]  active_cfg_reg;
    logic [3:0]  pend_cfg_reg;
    logic        cfg_pending_reg;
    logic [31:0] err_word_reg;
    logic [31:0] last_cmd_reg;
    logic [31:0] hv_reg, timing_reg;
    logic [31:0] retain_reg;
    logic [7:0]  cmd_cnt_reg;
    logic [31:0] mem_adr_reg;
    logic [15:0] init_cnt_reg;
    logic [31:0] wdog_cnt_reg;
    logic        check_tick, hist_tick;
    logic        err_set;
    logic [31:0] err_bits;
    logic [31:0] ram_sum;
    logic        cmd_wr, kick_wr;
    logic [3:0]  cmd_tgt;
    ims_pkg::ims_cmd_type cmd_type;
    assign cmd_wr  = wr_i && addr_i == ims_pkg::REG_CMD;
    assign kick_wr = wr_i && addr_i == ims_pkg::REG_KICK;
    assign cmd_tgt = wdata_i[ims_pkg::CMD_TGT_LSB +: 4];
    assign cmd_type = ims_pkg::ims_cmd_type'(wdata_i[ims_pkg::CMD_TYPE_LSB +: 4]);
    // periodic integrity check and histogram period
    ims_period_timer #(.PERIOD(CHECK_CYCLES)) u_check_timer (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .run_i     (state_reg != ST_BOOT),
        .tick_o    (check_tick)
    );
    ims_period_timer #(.PERIOD(HIST_CYCLES)) u_hist_timer (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .run_i     (state_reg == ST_SCIENCE),
        .tick_o    (hist_tick)
    );
    // ----------------------------------------------------------------
    // mode sequencing
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            state_reg       <= ST_BOOT;
            idx_reg         <= 8'h00;
            csum_reg        <= 32'h0000_0000;
            active_cfg_reg  <= 4'h0;
            pend_cfg_reg    <= 4'h0;
            cfg_pending_reg <= 1'b0;
            init_cnt_reg    <= 16'h0000;
            unit_pwr_o      <= 4'h0;
        end
        else
        begin
            case (state_reg)
                ST_BOOT:
                begin
                    idx_reg   <= 8'h00;
                    csum_reg  <= 32'h0000_0000;
                    state_reg <= ST_MEMCHK;
                end
                ST_MEMCHK:
                begin
                    // stored words plus appended checksum sum to zero
                    csum_reg <= csum_reg + nv_data_i;
                    idx_reg  <= idx_reg + 8'h01;
                    if (idx_reg == 8'(ims_pkg::PROC_WORDS))
                        state_reg <= ST_STANDBY;
                end
                ST_STANDBY:
                begin
                    if (cmd_wr && cmd_tgt == ims_pkg::TGT_CTRL)
                    begin
                        case (cmd_type)
                            ims_pkg::CT_CONFIG:
                            begin
                                pend_cfg_reg    <= wdata_i[3:0];
                                cfg_pending_reg <= 1'b1;
                            end
                            ims_pkg::CT_OPERATE:
                            begin
                                // default table unless a configuration preceded
                                if (!cfg_pending_reg)
                                    pend_cfg_reg <= 4'hF;
                                idx_reg   <= 8'h00;
                                state_reg <= ST_CFG_READ;
                            end
                            ims_pkg::CT_DIAG:
                                state_reg <= ST_DIAG;
                            ims_pkg::CT_SWOFF:
                                unit_pwr_o <= 4'h0;
                            ims_pkg::CT_UNIT_PWR:
                                unit_pwr_o <= wdata_i[3:0];
                            default:
                                cfg_pending_reg <= cfg_pending_reg;
                        endcase
                    end
                end
                ST_CFG_READ:
                begin
                    active_cfg_reg <= pend_cfg_reg & nv_data_i[3:0];
                    state_reg      <= ST_COPY;
                end
                ST_COPY:
                begin
                    idx_reg <= idx_reg + 8'h01;
                    if (idx_reg == 8'(ims_pkg::PROC_WORDS - 1))
                    begin
                        unit_pwr_o   <= active_cfg_reg;
                        init_cnt_reg <= 16'(ims_pkg::INIT_CYCLES);
                        state_reg    <= ST_INIT_WAIT;
                    end
                end
                ST_INIT_WAIT:
                begin
                    init_cnt_reg <= init_cnt_reg - 16'h0001;
                    if (init_cnt_reg == 16'h0000)
                    begin
                        cfg_pending_reg <= 1'b0;
                        if ((ok_s2_reg & active_cfg_reg) == active_cfg_reg)
                            state_reg <= ST_SCIENCE;
                        else
                            state_reg <= ST_STANDBY;
                    end
                end
                ST_SCIENCE, ST_DIAG:
                begin
                    // runs on until a reconfiguration command arrives
                    if (cmd_wr && cmd_tgt == ims_pkg::TGT_CTRL &&
                        (cmd_type == ims_pkg::CT_NOP || cmd_type == ims_pkg::CT_CONFIG))
                        state_reg <= ST_STANDBY;
                end
                default:
                    state_reg <= ST_BOOT;
            endcase
        end
    end
    assign nv_addr_o = idx_reg;
    always_ff @(posedge sys_clk_i)
    begin
        if (state_reg == ST_COPY)
            ram_reg[idx_reg[3:0]] <= nv_data_i;
    end
    // ----------------------------------------------------------------
    // error detection
    // ----------------------------------------------------------------
    always_comb
    begin
        err_bits = 32'h0000_0000;
        if (state_reg == ST_MEMCHK && idx_reg == 8'(ims_pkg::PROC_WORDS) &&
            csum_reg + nv_data_i != ims_pkg::CSUM_GOOD)
            err_bits[ims_pkg::ERR_BOOT] = 1'b1;
        // ram holds loaded code only once science is entered
        if (check_tick && state_reg == ST_SCIENCE && ram_sum != ims_pkg::CSUM_GOOD)
            err_bits[ims_pkg::ERR_CSUM] = 1'b1;
        if (wdog_cnt_reg == WDOG_CYCLES)
            err_bits[ims_pkg::ERR_WDOG] = 1'b1;
        if (state_reg == ST_INIT_WAIT && init_cnt_reg == 16'h0000 &&
            (ok_s2_reg & active_cfg_reg) != active_cfg_reg)
            err_bits[ims_pkg::ERR_INIT] = 1'b1;
        if (cmd_wr && cmd_tgt != ims_pkg::TGT_CTRL &&
            cmd_type != ims_pkg::CT_NOP && cmd_type != ims_pkg::CT_LOAD)
            err_bits[ims_pkg::ERR_BADCMD] = 1'b1;
    end
    always_comb
    begin
        ram_sum = 32'h0000_0000;
        for (int i = 0; i < ims_pkg::PROC_WORDS; i++)
            ram_sum = ram_sum + ram_reg[i];
    end
    assign err_set = |err_bits;
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i || kick_wr)
            wdog_cnt_reg <= 32'h0000_0000;
        else if (wdog_cnt_reg != WDOG_CYCLES)
            wdog_cnt_reg <= wdog_cnt_reg + 32'h0000_0001;
    end
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            err_word_reg <= 32'h0000_0000;
            err_flag_o   <= 1'b0;
        end
        else if (err_set)
        begin
            err_word_reg <= err_word_reg | err_bits;
            err_flag_o   <= 1'b1;
        end
        else if (cmd_wr && cmd_tgt == ims_pkg::TGT_CTRL && cmd_type == ims_pkg::CT_ERR_ACK)
        begin
            err_word_reg <= 32'h0000_0000;
            err_flag_o   <= 1'b0;
        end
    end
    // ----------------------------------------------------------------
    // command bookkeeping and retained status
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            last_cmd_reg <= 32'h0000_0000;
            cmd_cnt_reg  <= 8'h00;
            hv_reg       <= 32'h0000_0000;
            timing_reg   <= 32'h0000_0000;
            mem_adr_reg  <= 32'h0000_0000;
        end
        else
        begin
            if (cmd_wr)
            begin
                last_cmd_reg <= wdata_i;
                cmd_cnt_reg  <= cmd_cnt_reg + 8'h01;
            end
            if (wr_i && addr_i == ims_pkg::REG_HV)
                hv_reg <= wdata_i;
            if (wr_i && addr_i == ims_pkg::REG_TIMING)
                timing_reg <= wdata_i;
            if (wr_i && addr_i == ims_pkg::REG_MEMADR)
                mem_adr_reg <= wdata_i;
        end
    end
    // no reset: holds through a reset standing in for power cycling, then is rewritten each cycle once ST_BOOT is left
    always_ff @(posedge sys_clk_i)
    begin
        if (cmd_wr && cmd_tgt == ims_pkg::TGT_CTRL && cmd_type == ims_pkg::CT_CLR_STAT)
            retain_reg <= 32'h0000_0000;
        else if (!rst_i && state_reg != ST_BOOT)
            retain_reg <= {err_word_reg[23:0], 6'h00, mode_o};
    end
    // ----------------------------------------------------------------
    // histogram accumulation
    // ----------------------------------------------------------------
    logic [15:0] hist_reg [ims_pkg::N_BINS];
    logic [7:0]  bin_idx;
    logic        dumping_reg;
    logic [7:0]  dump_idx_reg;
    logic        hk_pending_reg;
    assign bin_idx = 8'(ev_s2_reg[7:4]) * 8'(ims_pkg::N_EN) + 8'(ev_s2_reg[3:0]);
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i || state_reg != ST_SCIENCE || hist_tick)
        begin
            for (int i = 0; i < ims_pkg::N_BINS; i++)
                hist_reg[i] <= 16'h0000;
        end
        else if (ev_s2_reg[8] && ev_s2_reg[7:4] < 4'(ims_pkg::N_AZ) &&
                 hist_reg[bin_idx] != 16'hFFFF)
            hist_reg[bin_idx] <= hist_reg[bin_idx] + 16'h0001;
    end
    // snapshot so counting restarts at once after each period
    logic [15:0] snap_reg [ims_pkg::N_BINS];
    always_ff @(posedge sys_clk_i)
    begin
        if (hist_tick)
            snap_reg <= hist_reg;
    end
    // ----------------------------------------------------------------
    // downlink stream: histogram words, pattern words in ST_DIAG, else health words per check period
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            dumping_reg    <= 1'b0;
            dump_idx_reg   <= 8'h00;
            hk_pending_reg <= 1'b0;
            tx_valid_o     <= 1'b0;
            tx_hk_o        <= 1'b0;
            tx_data_o      <= 32'h0000_0000;
        end
        else
        begin
            if (check_tick)
                hk_pending_reg <= 1'b1;
            if (hist_tick)
            begin
                dumping_reg  <= 1'b1;
                dump_idx_reg <= 8'h00;
            end
            if (!tx_valid_o || tx_ready_i)
            begin
                tx_valid_o <= 1'b0;
                if (dumping_reg && !hist_tick)
                begin
                    // raw counts with bin index in bits 23:16 and HV setting hv_reg[7:0] in top bits
                    tx_data_o  <= {hv_reg[7:0], dump_idx_reg, snap_reg[dump_idx_reg]};
                    tx_valid_o <= 1'b1;
                    tx_hk_o    <= 1'b0;
                    dump_idx_reg <= dump_idx_reg + 8'h01;
                    if (dump_idx_reg == 8'(ims_pkg::N_BINS - 1))
                        dumping_reg <= 1'b0;
                end
                else if (state_reg == ST_DIAG)
                begin
                    tx_data_o  <= {24'hA5A5A5, cmd_cnt_reg};
                    tx_valid_o <= 1'b1;
                    tx_hk_o    <= 1'b1;
                end
                else if (hk_pending_reg && !check_tick)
                begin
                    tx_data_o <= {cmd_cnt_reg, timing_reg[4:0], hv_reg[7:0],
                                  err_word_reg[4:0], ok_s2_reg, mode_o};
                    tx_valid_o     <= 1'b1;
                    tx_hk_o        <= 1'b1;
                    hk_pending_reg <= 1'b0;
                end
            end
        end
    end
    // ----------------------------------------------------------------
    // mode output and register reads
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
            mode_o <= ims_pkg::MODE_STANDBY;
        else if (state_reg == ST_SCIENCE)
            mode_o <= ims_pkg::MODE_SCIENCE;
        else if (state_reg == ST_DIAG)
            mode_o <= ims_pkg::MODE_DIAG;
        else
            mode_o <= ims_pkg::MODE_STANDBY;
    end
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i || !rd_i)
            rdata_o <= 32'h0000_0000;
        else
        begin
            case (addr_i)
                ims_pkg::REG_STATUS:  rdata_o <= {20'h00000, active_cfg_reg,
                                                  3'h0, err_flag_o, 2'h0, mode_o};
                ims_pkg::REG_ERRWORD: rdata_o <= err_word_reg;
                ims_pkg::REG_LASTCMD: rdata_o <= last_cmd_reg;
                ims_pkg::REG_CFG:     rdata_o <= {28'h0000000, pend_cfg_reg};
                ims_pkg::REG_HV:      rdata_o <= hv_reg;
                ims_pkg::REG_TIMING:  rdata_o <= timing_reg;
                ims_pkg::REG_MEMADR:  rdata_o <= mem_adr_reg;
                ims_pkg::REG_MEMDAT:  rdata_o <= ram_reg[mem_adr_reg[3:0]];
                ims_pkg::REG_RETAIN:  rdata_o <= retain_reg;
                default:              rdata_o <= 32'h0000_0000;
            endcase
        end
    end
endmodule
`default_nettype wire

// *** ims_sequencer_chk.sv ***
// port assertions for the instrument mode sequencer
`timescale 1ns/10ps
`default_nettype none
module ims_seq_chk (
    input wire logic        sys_clk_i, rst_i, wr_i, rd_i, tx_valid_o, tx_hk_o, tx_ready_i,
    input wire logic        err_flag_o,
    input wire logic [7:0]  addr_i,
    input wire logic [31:0] wdata_i, rdata_o, tx_data_o,
    input wire logic [3:0]  unit_pwr_o, unit_ok_i,
    input wire logic [1:0]  mode_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    wire logic cmd_w = wr_i && addr_i == ims_pkg::REG_CMD;
    wire logic ctl_w = cmd_w && wdata_i[31:28] == 4'h0;
    wire logic ack_w = ctl_w && wdata_i[27:24] == ims_pkg::CT_ERR_ACK;
    wire logic nop_w = ctl_w && wdata_i[27:25] == 3'h0;
    wire logic bad_w = cmd_w && wdata_i[31:28] != 4'h0 && wdata_i[27:24] != ims_pkg::CT_NOP
        && wdata_i[27:24] != ims_pkg::CT_LOAD;
    a_rdata_quiet: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
        else $error("read data outside read slot");
    a_boot_quiet: assert property ($fell(rst_i) |-> (mode_o == 2'h0 && unit_pwr_o == 4'h0) [*8])
        else $error("not quiet stand-by after reset");
    a_err_sticky: assert property ($fell(err_flag_o) |-> $past(ack_w) || $past(ack_w, 2))
        else $error("error flag dropped without ack");
    a_tx_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
        else $error("stream word not held");
    a_hist_sci: assert property ($rose(tx_valid_o) && !tx_hk_o |-> mode_o == 2'h1)
        else $error("histogram outside science");
    a_units_ok: assert property (mode_o == 2'h1 && $past(mode_o) != 2'h1 |->
        (unit_pwr_o & ~unit_ok_i) == 4'h0) else $error("science with failed unit");
    a_bad_err: assert property (bad_w |-> ##[1:3] err_flag_o)
        else $error("bad sensor command not flagged");
    a_nop_stby: assert property (nop_w && mode_o != 2'h0 |-> ##[1:4] mode_o == 2'h0)
        else $error("no stand-by after nop");
    c_sci: cover property (mode_o == 2'h1);
    c_ack: cover property ($fell(err_flag_o));
    c_hist: cover property (tx_valid_o && tx_ready_i && !tx_hk_o);
endmodule
bind ims_sequencer ims_seq_chk i_chk (.sys_clk_i, .rst_i, .wr_i, .rd_i, .tx_valid_o, .tx_hk_o,
    .tx_ready_i, .err_flag_o, .addr_i, .wdata_i, .rdata_o, .tx_data_o, .unit_pwr_o,
    .unit_ok_i, .mode_o);
`default_nettype wire

// *** ims_sc_model.sv ***
// downlink receiver of the spacecraft handling unit
`timescale 1ns/10ps
`default_nettype none
module ims_sc_model (
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    input  wire logic slow_i,
    input  wire logic tx_valid_i,
    input  wire logic tx_hk_i,
    output logic      tx_ready_o,
    output int        n_hist_o,
    input  wire logic [31:0] tx_data_i,
    output logic      [31:0] hit_o
);
    logic [1:0] div_reg;
    // slow takes one word in four so the design must hold its words
    assign tx_ready_o = !slow_i || div_reg == 2'h3;
    always_ff @(posedge sys_clk_i)
    begin
        div_reg  <= rst_i ? 2'h0 : div_reg + 2'h1;
        n_hist_o <= rst_i ? 0 : n_hist_o + int'(tx_valid_i && tx_ready_o && !tx_hk_i);
        // last histogram word that carries a nonzero count
        if (tx_valid_i && tx_ready_o && !tx_hk_i && tx_data_i[15:0] != 16'h0000)
            hit_o <= tx_data_i;
    end
endmodule
`default_nettype wire

// *** instrument_mode_sequencer_test.sv ***
// self-checking bench for the instrument mode sequencer
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end
module instrument_mode_sequencer_test;
    logic        sys_clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, event_i = 0, slow = 0;
    logic [7:0]  addr_i = 8'h00, nv_addr_o;
    logic [31:0] wdata_i = 32'h0, rdata_o, tx_data_o, rd_v, hit;
    logic [3:0]  unit_ok_i = 4'hF, unit_pwr_o, az = 4'h3, en = 4'h5;
    logic        tx_valid_o, tx_hk_o, tx_ready, err_flag_o;
    logic [1:0]  mode_o;
    int          errors = 0, n_checks = 0, cyc = 0, n_hist;
    // long periods shortened; periodic checksum and watchdog kept out of the run
    ims_sequencer #(.HIST_CYCLES(64'd2000), .CHECK_CYCLES(64'd90000), .WDOG_CYCLES(90000)) i_dut (
        .sys_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .nv_addr_o,
        .nv_data_i(32'h0000_000F), .unit_pwr_o, .unit_ok_i, .event_i, .event_az_i(az),
        .event_en_i(en), .tx_data_o, .tx_valid_o, .tx_hk_o, .tx_ready_i(tx_ready), .mode_o,
        .err_flag_o);
    ims_sc_model i_sc (.sys_clk_i, .rst_i, .slow_i(slow), .tx_valid_i(tx_valid_o),
        .tx_hk_i(tx_hk_o), .tx_ready_o(tx_ready), .n_hist_o(n_hist), .tx_data_i(tx_data_o),
        .hit_o(hit));
    initial forever #4 sys_clk_i = ~sys_clk_i;
    task wrap_up;
        $display("errors %0d checks %0d", errors, n_checks);
        if (errors == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge sys_clk_i) if (++cyc == 40000) begin errors++; wrap_up(); end
    task cmd(input logic [31:0] d);
        @(posedge sys_clk_i); addr_i <= ims_pkg::REG_CMD; wdata_i <= d; wr_i <= 1;
        @(posedge sys_clk_i); wr_i <= 0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge sys_clk_i); addr_i <= a; rd_i <= 1;
        @(posedge sys_clk_i); rd_i <= 0;
        @(negedge sys_clk_i); rd_v = rdata_o;
    endtask
    task pause(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    initial
    begin
        pause(6); rst_i <= 0; pause(25);
        `CHK("mode", 2'h0, mode_o)
        `CHK("power", 4'h0, unit_pwr_o)
        `CHK("boot err", 1'b1, err_flag_o)
        cmd(32'h0A00_0000); cmd(32'h1300_0000); pause(4);
        `CHK("err set", 1'b1, err_flag_o)
        rd(ims_pkg::REG_ERRWORD); `CHK("err word", 1'b1, rd_v[ims_pkg::ERR_BADCMD])
        rd(ims_pkg::REG_LASTCMD); `CHK("last cmd", 32'h1300_0000, rd_v)
        cmd(32'h0A00_0000); pause(3); `CHK("err ack", 1'b0, err_flag_o)
        cmd(32'h0100_000F); cmd(32'h0200_0000);
        for (int i = 0; i < 14000 && mode_o !== 2'h1; i++) pause(1);
        `CHK("science", 2'h1, mode_o)
        `CHK("units on", 4'hF, unit_pwr_o)
        event_i <= 1; slow <= 1; pause(10); event_i <= 0;
        for (int i = 0; i < 6000 && n_hist < 192; i++) pause(1);
        pause(20); `CHK("hist words", 192, n_hist)
        `CHK("hist bin", ({8'h00, 8'(az * ims_pkg::N_EN + en), 16'h000A}), hit)
        cmd(32'h0000_0000); pause(5); `CHK("nop", 2'h0, mode_o)
        unit_ok_i <= 4'h0; cmd(32'h0200_0000); pause(12700);
        `CHK("init fail mode", 2'h0, mode_o)
        `CHK("init fail err", 1'b1, err_flag_o)
        wrap_up();
    end
endmodule
`default_nettype wire
